// *** design/dwd_consts.svh ***
`ifndef DWD_CONSTS_SVH
`define DWD_CONSTS_SVH

// ----------------------------------------------------------------
// rates
// ----------------------------------------------------------------
`define DWD_CORE_HZ        25000000
`define DWD_RC_HZ          128000

// ----------------------------------------------------------------
// window watchdog counter
// ----------------------------------------------------------------
`define DWD_WWDG_W         7
`define DWD_WWDG_ARM_BIT   6
`define DWD_WWDG_EXPIRE    7'h3f
`define DWD_WWDG_RST_VAL   7'h7f
`define DWD_WWDG_WIN_RST   7'h7f
`define DWD_WWDG_TICK_CYC  12288

// ----------------------------------------------------------------
// independent watchdog counter
// ----------------------------------------------------------------
`define DWD_IWDG_W         8
`define DWD_IWDG_RST_VAL   8'hff
`define DWD_IWDG_PRE_W     3
`define DWD_IWDG_DIV_W     10
`define DWD_IWDG_DIV_BASE  2

`endif

// *** design/dwd_iwdg.sv ***
`include "dwd_consts.svh"

module dwd_iwdg (
  input  logic                       core_clk,
  input  logic                       rstn,
  input  logic                       low_speed_internal_rc_clock,
  input  logic                       opt_hw_iwdg,
  input  dwd_pkg::dwd_iwdg_cmd_s     cmd,
  output logic                       active,
  output logic [`DWD_IWDG_W-1:0]     count,
  output logic                       rst_pulse
);

  dwd_pkg::dwd_iwdg_state_s st_r;
  dwd_pkg::dwd_iwdg_state_s st_nxt;
  logic                     rc_rise;
  logic [`DWD_IWDG_DIV_W-1:0] div_lim;

  // ----------------------------------------------------------------
  // counting clock: three-stage sync, edge once stages 2 and 3 agree
  // ----------------------------------------------------------------
  // rc edge detect
  assign rc_rise  = st_r.s2 & st_r.s3 & ~st_r.lvl;
  assign div_lim  = `DWD_IWDG_DIV_W'((`DWD_IWDG_DIV_BASE << st_r.prescale) - 1);

  always_comb begin
    st_nxt           = st_r;
    st_nxt.s1        = low_speed_internal_rc_clock;
    st_nxt.s2        = st_r.s1;
    st_nxt.s3        = st_r.s2;
    st_nxt.rst_pulse = 1'b0;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
    if (!st_r.opt_taken) begin
      st_nxt.opt_taken = 1'b1;
      if (opt_hw_iwdg) begin
        st_nxt.st = dwd_pkg::WD_RUN;
      end
    end
    case (st_r.st)
      dwd_pkg::WD_OFF: begin
        if (cmd.start) begin
          st_nxt.st       = dwd_pkg::WD_RUN;
          st_nxt.reload   = cmd.reload;
          st_nxt.prescale = cmd.prescale;
          st_nxt.count    = cmd.reload;
          st_nxt.div      = '0;
        end
      end
      dwd_pkg::WD_RUN: begin
        // no stop path, start is ignored once running
        if (cmd.key_write) begin
          st_nxt.count = st_r.reload;
          st_nxt.div   = '0;
        end else if (rc_rise) begin
          if (st_r.div == div_lim) begin
            st_nxt.div = '0;
            if (st_r.count == '0) begin
              st_nxt.st        = dwd_pkg::WD_FIRED;
              st_nxt.rst_pulse = 1'b1;
            end else begin
              st_nxt.count = st_r.count - 1'b1;
            end
          end else begin
            st_nxt.div = st_r.div + 1'b1;
          end
        end
      end
      dwd_pkg::WD_FIRED: begin
        st_nxt.st = dwd_pkg::WD_FIRED;
      end
      default: begin
        st_nxt.st = dwd_pkg::WD_OFF;
      end
    endcase
    // active is a flop of its own so the port needs no decode
    st_nxt.active = (st_nxt.st != dwd_pkg::WD_OFF);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r          <= '0;
      st_r.st       <= dwd_pkg::WD_OFF;
      st_r.count    <= `DWD_IWDG_RST_VAL;
      st_r.reload   <= `DWD_IWDG_RST_VAL;
      // sampler keeps running through reset so no false edge follows it;
      // an edge that falls inside reset is lost instead
      st_r.s1       <= low_speed_internal_rc_clock;
      st_r.s2       <= st_r.s1;
      st_r.s3       <= st_r.s2;
      st_r.lvl      <= st_r.s2;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active    = st_r.active;
  assign count     = st_r.count;
  assign rst_pulse = st_r.rst_pulse;

endmodule

// *** design/dwd_pkg.sv ***
`include "dwd_consts.svh"

package dwd_pkg;

  typedef enum logic [1:0] {
    WD_OFF,
    WD_RUN,
    WD_FIRED
  } dwd_state_e;

  // software commands to the window watchdog (one-cycle strobes plus data)
  typedef struct packed {
    logic                       start;
    logic                       reload;
    logic [`DWD_WWDG_W-1:0]     value;
    logic                       set_window;
    logic [`DWD_WWDG_W-1:0]     window;
  } dwd_wwdg_cmd_s;

  // software commands to the independent watchdog
  typedef struct packed {
    logic                       start;
    logic                       key_write;
    logic [`DWD_IWDG_W-1:0]     reload;
    logic [`DWD_IWDG_PRE_W-1:0] prescale;
  } dwd_iwdg_cmd_s;

  typedef struct packed {
    logic                       s1;
    logic                       s2;
    logic                       s3;
    logic                       lvl;
    dwd_state_e                 st;
    logic [`DWD_IWDG_DIV_W-1:0] div;
    logic [`DWD_IWDG_W-1:0]     count;
    logic [`DWD_IWDG_W-1:0]     reload;
    logic [`DWD_IWDG_PRE_W-1:0] prescale;
    logic                       rst_pulse;
    logic                       opt_taken;
    logic                       active;
  } dwd_iwdg_state_s;

  typedef struct packed {
    dwd_state_e                 st;
    logic [15:0]                tick;
    logic [`DWD_WWDG_W-1:0]     count;
    logic [`DWD_WWDG_W-1:0]     window;
    logic                       opt_taken;
    logic                       rst_req;
    logic                       cause_wwdg;
    logic                       cause_iwdg;
    logic                       active;
  } dwd_top_state_s;

endpackage

// *** design/dwd_top.sv ***
`include "dwd_consts.svh"

module dwd_top #(
  parameter int WWDG_TICK_CYC = `DWD_WWDG_TICK_CYC
) (
  input  logic                       core_clk,
  input  logic                       rstn,
  input  logic                       low_speed_internal_rc_clock,
  input  logic                       opt_hw_wwdg,
  input  logic                       opt_hw_iwdg,
  input  dwd_pkg::dwd_wwdg_cmd_s     wwdg_cmd,
  input  dwd_pkg::dwd_iwdg_cmd_s     iwdg_cmd,
  output logic                       wwdg_active,
  output logic [`DWD_WWDG_W-1:0]     wwdg_count,
  output logic                       iwdg_active,
  output logic [`DWD_IWDG_W-1:0]     iwdg_count,
  output logic                       sys_rst_req,
  output logic                       cause_wwdg,
  output logic                       cause_iwdg
);

  dwd_pkg::dwd_top_state_s st_r;
  dwd_pkg::dwd_top_state_s st_nxt;
  logic                    iwdg_fire;
  logic                    wwdg_fire;
  logic [15:0]             tick_lim;
  logic                    opt_start;
  logic                    sw_start;
  logic                    running;
  logic                    tick_wrap;
  logic                    in_window;
  logic                    reload_early;
  logic                    reload_disarm;
  logic                    reload_bad;
  logic                    reload_good;
  logic                    step_due;
  logic                    step_expire;
  logic                    count_disarmed;
  logic                    req_set;

  // ----------------------------------------------------------------
  // independent watchdog
  // ----------------------------------------------------------------
  dwd_iwdg u_iwdg (
    .core_clk                    (core_clk),
    .rstn                        (rstn),
    .low_speed_internal_rc_clock (low_speed_internal_rc_clock),
    .opt_hw_iwdg                 (opt_hw_iwdg),
    .cmd                         (iwdg_cmd),
    .active                      (iwdg_active),
    .count                       (iwdg_count),
    .rst_pulse                   (iwdg_fire)
  );

  // ----------------------------------------------------------------
  // option start
  // ----------------------------------------------------------------
  // the option pin is read on the first clock after reset and never again,
  // so a later change on it can neither start nor stop the counter
  // option start
  assign opt_start = ~st_r.opt_taken & opt_hw_wwdg;

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  assign running   = (st_r.st == dwd_pkg::WD_RUN);
  assign tick_lim  = 16'(WWDG_TICK_CYC - 1);
  assign tick_wrap = (st_r.tick == tick_lim);
  assign in_window = (st_r.count <= st_r.window);

  assign sw_start = (st_r.st == dwd_pkg::WD_OFF) & wwdg_cmd.start;

  assign reload_early = running & wwdg_cmd.reload & ~in_window;

  assign reload_disarm = running & wwdg_cmd.reload & ~wwdg_cmd.value[`DWD_WWDG_ARM_BIT];

  assign reload_bad  = reload_early | reload_disarm;
  assign reload_good = running & wwdg_cmd.reload & ~reload_bad;

  // a reload restarts the step timer, so a step never shares its cycle
  assign step_due = running & ~wwdg_cmd.reload & tick_wrap;

  assign step_expire = step_due & (st_r.count == (`DWD_WWDG_EXPIRE + 7'h01));

  // a start value without the arm bit would only reach the expire point after wrapping through zero,
  // so it counts as already expired rather than running on through the wrap
  // disarmed count fires
  assign count_disarmed = running & ~st_r.count[`DWD_WWDG_ARM_BIT];

  assign wwdg_fire = reload_bad | step_expire | count_disarmed;

  // ----------------------------------------------------------------
  // reset request
  // ----------------------------------------------------------------
  // both causes are kept, but rstn clears them, so software cannot tell after restart which one fired
  // request set
  assign req_set = wwdg_fire | iwdg_fire;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.opt_taken = 1'b1;
    if (opt_start) begin
      st_nxt.st = dwd_pkg::WD_RUN;
    end
    // window may move in any state, it only matters at reload
    if (wwdg_cmd.set_window) begin
      st_nxt.window = wwdg_cmd.window;
    end
    case (st_r.st)
      dwd_pkg::WD_OFF: begin
        if (sw_start) begin
          st_nxt.st    = dwd_pkg::WD_RUN;
          st_nxt.count = wwdg_cmd.value;
          st_nxt.tick  = '0;
        end
      end
      dwd_pkg::WD_RUN: begin
        if (reload_good) begin
          st_nxt.count = wwdg_cmd.value;
          st_nxt.tick  = '0;
        end else if (step_due) begin
          st_nxt.count = st_r.count - 1'b1;
          st_nxt.tick  = '0;
        end else if (!wwdg_cmd.reload) begin
          st_nxt.tick = st_r.tick + 1'b1;
        end
        if (wwdg_fire) begin
          st_nxt.st = dwd_pkg::WD_FIRED;
        end
      end
      dwd_pkg::WD_FIRED: begin
        st_nxt.st = dwd_pkg::WD_FIRED;
      end
      default: begin
        st_nxt.st = dwd_pkg::WD_OFF;
      end
    endcase
    if (req_set) begin
      st_nxt.rst_req = 1'b1;
    end
    if (wwdg_fire) begin
      st_nxt.cause_wwdg = 1'b1;
    end
    if (iwdg_fire) begin
      st_nxt.cause_iwdg = 1'b1;
    end
    // active is a flop of its own so the port needs no decode
    st_nxt.active = (st_nxt.st != dwd_pkg::WD_OFF);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // stickiness trades a fixed pulse width for a request that holds until rstn
  // goes low, however long the reset controller takes to act
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r        <= '0;
      st_r.st     <= dwd_pkg::WD_OFF;
      st_r.count  <= `DWD_WWDG_RST_VAL;
      st_r.window <= `DWD_WWDG_WIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wwdg_active = st_r.active;
  assign wwdg_count  = st_r.count;
  assign sys_rst_req = st_r.rst_req;
  assign cause_wwdg  = st_r.cause_wwdg;
  assign cause_iwdg  = st_r.cause_iwdg;

endmodule

// *** tb/dwd_chk.sv ***
`include "dwd_consts.svh"
module dwd_chk #(
  parameter int WWDG_TICK_CYC = 4
) (
  input logic                   core_clk,
  input logic                   rstn,
  input logic                   opt_hw_iwdg,
  input dwd_pkg::dwd_wwdg_cmd_s wwdg_cmd,
  input dwd_pkg::dwd_iwdg_cmd_s iwdg_cmd,
  input logic                   wwdg_active,
  input logic [`DWD_WWDG_W-1:0] wwdg_count,
  input logic                   iwdg_active,
  input logic [`DWD_IWDG_W-1:0] iwdg_count,
  input logic                   sys_rst_req,
  input logic                   cause_wwdg,
  input logic                   cause_iwdg
);
  timeunit 1ns / 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // --
  // bad reload and steps
  // --
  sequence ww_bad;
    wwdg_active && !sys_rst_req && wwdg_cmd.reload && !wwdg_cmd.value[6];
  endsequence
  sequence ww_drop;
    wwdg_active && !$past(sys_rst_req) && $fell(wwdg_count[6]);
  endsequence
  // fired counter may do anything, so steps are only judged before firing
  sequence iw_step;
    iwdg_active && !sys_rst_req && $changed(iwdg_count)
      && !$past(iwdg_cmd.start) && !$past(iwdg_cmd.key_write);
  endsequence
  AST_REQ_HELD: assert property (sys_rst_req |=> sys_rst_req)
    else $error("request dropped");
  AST_WW_ON: assert property (wwdg_active |=> wwdg_active)
    else $error("window stopped");
  AST_IW_ON: assert property (iwdg_active |=> iwdg_active)
    else $error("independent stopped");
  AST_IW_OPT: assert property ($rose(rstn) && opt_hw_iwdg
    |=> iwdg_active && iwdg_count == 8'hff) else $error("no option start");
  AST_IW_START: assert property (iwdg_cmd.start && !iwdg_active
    |=> iwdg_active && iwdg_count == $past(iwdg_cmd.reload)) else $error("no start");
  AST_WW_BAD: assert property (ww_bad |=> sys_rst_req && cause_wwdg)
    else $error("bad reload kept");
  AST_WW_TIMEOUT: assert property (ww_drop |-> ##[0:1] (sys_rst_req && cause_wwdg))
    else $error("no timeout");
  AST_IW_STEP: assert property (iw_step |-> iwdg_count == $past(iwdg_count) - 8'h01)
    else $error("bad step");
  AST_IW_FIRE: assert property ($rose(cause_iwdg) |-> sys_rst_req && iwdg_count == 8'h00)
    else $error("early fire");
endmodule

bind dwd_top dwd_chk #(.WWDG_TICK_CYC(WWDG_TICK_CYC)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .opt_hw_iwdg(opt_hw_iwdg), .wwdg_cmd(wwdg_cmd),
  .iwdg_cmd(iwdg_cmd), .wwdg_active(wwdg_active), .wwdg_count(wwdg_count),
  .iwdg_active(iwdg_active), .iwdg_count(iwdg_count), .sys_rst_req(sys_rst_req),
  .cause_wwdg(cause_wwdg), .cause_iwdg(cause_iwdg)
);

// *** tb/dwd_top_tb.sv ***
`include "dwd_consts.svh"
module dwd_top_tb;
  timeunit 1ns / 1ns;
  localparam int TICK = 4;
  localparam int RC_HALF = 3906;
  logic                   core_clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   rc_clk = 1'b0;
  logic                   opt_hw_wwdg = 1'b0;
  logic                   opt_hw_iwdg = 1'b0;
  dwd_pkg::dwd_wwdg_cmd_s wwdg_cmd = '0;
  dwd_pkg::dwd_iwdg_cmd_s iwdg_cmd = '0;
  logic                   wwdg_active;
  logic [6:0]             wwdg_count;
  logic                   iwdg_active;
  logic [7:0]             iwdg_count;
  logic                   sys_rst_req;
  logic                   cause_wwdg;
  logic                   cause_iwdg;
  logic [7:0]             v;
  logic [2:0]             p;
  int                     n;
  int                     error_cnt = 0;
  int                     checks = 0;
  wire  [7:0]             flags;
  assign flags = {3'h0, wwdg_active, iwdg_active, sys_rst_req, cause_wwdg, cause_iwdg};
  always #20 core_clk = ~core_clk;
  // rc clock runs free and drifts against the core clock
  always #RC_HALF rc_clk = ~rc_clk;
  dwd_top #(.WWDG_TICK_CYC(TICK)) dut (
    .core_clk(core_clk), .rstn(rstn), .low_speed_internal_rc_clock(rc_clk),
    .opt_hw_wwdg(opt_hw_wwdg), .opt_hw_iwdg(opt_hw_iwdg), .wwdg_cmd(wwdg_cmd),
    .iwdg_cmd(iwdg_cmd), .wwdg_active(wwdg_active), .wwdg_count(wwdg_count),
    .iwdg_active(iwdg_active), .iwdg_count(iwdg_count), .sys_rst_req(sys_rst_req),
    .cause_wwdg(cause_wwdg), .cause_iwdg(cause_iwdg)
  );
  function automatic int iw_cyc(input int r, input logic [2:0] q);
    return (r + 1) * (2 << q) * RC_HALF / 20;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic ow, input logic oi);
    rstn = 1'b0;
    opt_hw_wwdg = ow;
    opt_hw_iwdg = oi;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
  endtask
  // strobes drop for a whole cycle so two commands never share a time step
  task automatic ww(input logic s, input logic r, input logic w, input logic [6:0] d);
    wwdg_cmd = '{s, r, d, w, d};
    @(negedge core_clk);
    wwdg_cmd = '0;
    @(negedge core_clk);
  endtask
  task automatic iw(input logic s, input logic k, input logic [7:0] r, input logic [2:0] q);
    iwdg_cmd = '{s, k, r, q};
    @(negedge core_clk);
    iwdg_cmd = '0;
    @(negedge core_clk);
  endtask
  task automatic wait_req(input int lim);
    n = 0;
    while (sys_rst_req !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        error_cnt++;
        $display("wrong value at %0t: no request", $time);
        test_done();
      end
    end
  endtask
  initial begin
    void'($urandom(17));
    do_reset(1'b1, 1'b1);
    chk(flags, 8'h18);
    chk({1'b0, wwdg_count}, 8'h7f);
    chk(iwdg_count, 8'hff);
    do_reset(1'b0, 1'b0);
    iw(1'b0, 1'b1, 8'h05, 3'h0);
    chk(flags, 8'h00);
    $display("test 1 done");
    v = 8'h50 + 8'($urandom % 48);
    ww(1'b1, 1'b0, 1'b1, v[6:0]);
    ww(1'b0, 1'b1, 1'b0, v[6:0]);
    chk({1'b0, wwdg_count}, v);
    ww(1'b1, 1'b0, 1'b0, 7'h7f);
    chk(flags, 8'h10);
    ww(1'b0, 1'b0, 1'b1, 7'h40);
    ww(1'b0, 1'b1, 1'b0, 7'h7f);
    chk(flags, 8'h16);
    do_reset(1'b0, 1'b0);
    ww(1'b1, 1'b0, 1'b0, 7'h7f);
    ww(1'b0, 1'b1, 1'b0, {1'b0, v[5:0]});
    chk(flags, 8'h16);
    do_reset(1'b0, 1'b0);
    ww(1'b1, 1'b0, 1'b0, {1'b0, v[5:0]});
    chk(flags, 8'h16);
    $display("test 2 done");
    do_reset(1'b1, 1'b0);
    wait_req(64 * TICK + 8);
    chk(flags, 8'h16);
    chk({7'h00, n >= 64 * TICK - 4}, 8'h01);
    $display("test 3 done");
    do_reset(1'b0, 1'b0);
    v = 8'h02 + 8'($urandom % 2);
    p = 3'($urandom % 2);
    iw(1'b1, 1'b0, v, p);
    chk(iwdg_count, v);
    repeat (500) @(negedge core_clk);
    iw(1'b0, 1'b1, 8'h00, 3'h0);
    chk(iwdg_count, v);
    wait_req(iw_cyc(v, p) + 400);
    chk(flags, 8'h0d);
    chk({7'h00, n >= iw_cyc(v - 1, p)}, 8'h01);
    $display("test 4 done");
    test_done();
  end
endmodule
